//--- inc/mirqc_params.svh
`ifndef MIRQC_PARAMS_SVH
`define MIRQC_PARAMS_SVH
`define MIRQC_ADDR_W          9
`define MIRQC_OFS_CONTROL     9'h00b
`define MIRQC_OFS_CONTROL_HI  9'h08b
`define MIRQC_OFS_PFLAGS      9'h00c
`define MIRQC_OFS_PENABLES    9'h08c
`define MIRQC_OFS_PORT_SEL    9'h096
`define MIRQC_RST_CONTROL     8'h00
`define MIRQC_RST_PFLAGS      8'h00
`define MIRQC_RST_PENABLES    8'h00
`define MIRQC_RST_PORT_SEL    8'h00
`define MIRQC_BIT_MASTER      7
`define MIRQC_BIT_PGATE       6
`define MIRQC_BIT_T8_EN       5
`define MIRQC_BIT_EXT_EN      4
`define MIRQC_BIT_PC_EN       3
`define MIRQC_BIT_T8_FLAG     2
`define MIRQC_BIT_EXT_FLAG    1
`define MIRQC_BIT_PC_FLAG     0
`define MIRQC_VECTOR          13'h0004
`define MIRQC_PHASE_Q1        2'h0
`define MIRQC_PHASE_Q2        2'h1
`define MIRQC_PHASE_Q4        2'h3
`endif

//--- inc/mirqc_pkg.sv
package mirqc_pkg;
    typedef struct packed {
        logic eeprom_write;
        logic adc_done;
        logic capcomp;
        logic comparator_b;
        logic comparator_a;
        logic clock_fail;
        logic match_timer;
        logic timer16_ovf;
    } mirqc_periph_t;
    typedef struct packed {
        logic       take;
        logic [12:0] vector;
    } mirqc_vec_t;
    typedef enum logic [1:0] {
        MIRQC_RUN,
        MIRQC_SLEEP,
        MIRQC_WAKE_STEP
    } mirqc_state_t;
endpackage

//--- rtl/mirqc_top.sv
// Our own choice: strobed register access.
`include "mirqc_params.svh"
module mirqc_top (
    input  wire logic                   clk_sys_i,
    input  wire logic                   reset_i,
    input  wire logic [1:0]             q_phase_i,
    input  wire logic                   ext_pin_i,
    input  wire logic                   ext_edge_select_i,
    input  wire logic [7:0]             port_pins_i,
    input  wire logic                   port_read_i,
    input  wire logic                   timer8_ovf_i,
    input  wire mirqc_pkg::mirqc_periph_t periph_evt_i,
    input  wire logic                   instr_end_i,
    input  wire logic                   return_from_irq_instr_i,
    input  wire logic                   sleep_instr_i,
    input  wire logic [`MIRQC_ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_write_i,
    input  wire logic                   reg_read_i,
    output logic      [7:0]             reg_rdata_o,
    output logic                        core_irq_o,
    output logic                        stack_push_o,
    output mirqc_pkg::mirqc_vec_t       vector_o,
    output logic                        wake_o,
    output logic                        asleep_o
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]              control_reg;
    logic [7:0]              pflags_reg;
    logic [7:0]              penables_reg;
    logic [7:0]              port_sel_reg;
    logic [1:0]              ext_sync_reg;
    logic                    ext_prev_reg;
    logic [7:0]              port_sync1_reg;
    logic [7:0]              port_sync2_reg;
    logic [7:0]              port_latch_reg;
    logic                    pending_reg;
    logic                    take;
    logic                    wake_req;
    mirqc_pkg::mirqc_state_t state_reg;
    logic                    ext_edge;
    logic                    port_change;
    logic                    wr_ctl;
    logic                    wr_pf;
    logic                    q41;

    function automatic logic hit(input logic [`MIRQC_ADDR_W-1:0] a,
                                 input logic [`MIRQC_ADDR_W-1:0] b);
        hit = (a == b);
    endfunction

    assign wr_ctl = reg_write_i && (hit(reg_addr_i, `MIRQC_OFS_CONTROL) ||
                                    hit(reg_addr_i, `MIRQC_OFS_CONTROL_HI));
    assign wr_pf  = reg_write_i && hit(reg_addr_i, `MIRQC_OFS_PFLAGS);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ext_sync_reg   <= 2'h0;
            ext_prev_reg   <= 1'b0;
            port_sync1_reg <= 8'h00;
            port_sync2_reg <= 8'h00;
        end else begin
            ext_sync_reg   <= {ext_sync_reg[0], ext_pin_i};
            ext_prev_reg   <= ext_sync_reg[1];
            port_sync1_reg <= port_pins_i;
            port_sync2_reg <= port_sync1_reg;
        end
    end

    // edge held in ext_hold_reg until a q4/q1 window lets it set the flag
    assign q41      = (q_phase_i == `MIRQC_PHASE_Q4) || (q_phase_i == `MIRQC_PHASE_Q1);
    assign ext_edge = ext_edge_select_i ? (ext_sync_reg[1] && !ext_prev_reg)
                                        : (!ext_sync_reg[1] && ext_prev_reg);

    // port latch reloads on a q2 read; a change meeting the read still sets the flag from the old latch
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            port_latch_reg <= 8'h00;
        end else if (port_read_i && q_phase_i == `MIRQC_PHASE_Q2) begin
            port_latch_reg <= port_sync2_reg;
        end
    end
    assign port_change = |((port_sync2_reg ^ port_latch_reg) & port_sel_reg);

    logic ext_hold_reg;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ext_hold_reg <= 1'b0;
        end else if (q41) begin
            ext_hold_reg <= 1'b0;
        end else if (ext_edge) begin
            ext_hold_reg <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // control register; hardware sets win over software clears
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            control_reg <= `MIRQC_RST_CONTROL;
        end else begin
            logic [7:0] n;
            n = wr_ctl ? reg_wdata_i : control_reg;
            if (take) begin
                n[`MIRQC_BIT_MASTER] = 1'b0;
            end
            if (return_from_irq_instr_i) begin
                n[`MIRQC_BIT_MASTER] = 1'b1;
            end
            if ((ext_edge || ext_hold_reg) && q41) begin
                n[`MIRQC_BIT_EXT_FLAG] = 1'b1;
            end
            if (timer8_ovf_i) begin
                n[`MIRQC_BIT_T8_FLAG] = 1'b1;
            end
            if (port_change) begin
                n[`MIRQC_BIT_PC_FLAG] = 1'b1;
            end
            control_reg <= n;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pflags_reg <= `MIRQC_RST_PFLAGS;
        end else begin
            // events are or-ed in after the write so a clear never hides a new event
            pflags_reg <= (wr_pf ? reg_wdata_i : pflags_reg) | periph_evt_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            penables_reg <= `MIRQC_RST_PENABLES;
            port_sel_reg <= `MIRQC_RST_PORT_SEL;
        end else if (reg_write_i) begin
            if (hit(reg_addr_i, `MIRQC_OFS_PENABLES)) begin
                // per-pin change selects share this write path
                penables_reg <= reg_wdata_i;
            end else if (hit(reg_addr_i, `MIRQC_OFS_PORT_SEL)) begin
                port_sel_reg <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            if (hit(reg_addr_i, `MIRQC_OFS_CONTROL) || hit(reg_addr_i, `MIRQC_OFS_CONTROL_HI)) begin
                reg_rdata_o <= control_reg;
            end else if (hit(reg_addr_i, `MIRQC_OFS_PFLAGS)) begin
                reg_rdata_o <= pflags_reg;
            end else if (hit(reg_addr_i, `MIRQC_OFS_PENABLES)) begin
                reg_rdata_o <= penables_reg;
            end else if (hit(reg_addr_i, `MIRQC_OFS_PORT_SEL)) begin
                reg_rdata_o <= port_sel_reg;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // request tree; flags stay set while blocked so nothing is lost
    assign pending_reg = (control_reg[`MIRQC_BIT_EXT_EN] && control_reg[`MIRQC_BIT_EXT_FLAG]) ||
                         (control_reg[`MIRQC_BIT_T8_EN] && control_reg[`MIRQC_BIT_T8_FLAG]) ||
                         (control_reg[`MIRQC_BIT_PC_EN] && control_reg[`MIRQC_BIT_PC_FLAG]) ||
                         (control_reg[`MIRQC_BIT_PGATE] && |(pflags_reg & penables_reg));
    assign wake_req    = pending_reg;
    assign core_irq_o  = control_reg[`MIRQC_BIT_MASTER] && pending_reg;
    // taken only at an instruction boundary, so a 2 cycle op delays the take until its end
    assign take = core_irq_o && instr_end_i && (state_reg != mirqc_pkg::MIRQC_SLEEP) &&
                  !wr_ctl;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= mirqc_pkg::MIRQC_RUN;
        end else begin
            case (state_reg)
                mirqc_pkg::MIRQC_RUN: begin
                    if (sleep_instr_i) begin
                        state_reg <= mirqc_pkg::MIRQC_SLEEP;
                    end
                end
                // sleep ends on any enabled flag, whatever the master enable says
                mirqc_pkg::MIRQC_SLEEP: begin
                    if (wake_req) begin
                        state_reg <= mirqc_pkg::MIRQC_WAKE_STEP;
                    end
                end
                mirqc_pkg::MIRQC_WAKE_STEP: begin
                    if (instr_end_i) begin
                        state_reg <= mirqc_pkg::MIRQC_RUN;
                    end
                end
                default: begin
                    state_reg <= mirqc_pkg::MIRQC_RUN;
                end
            endcase
        end
    end

    assign wake_o   = (state_reg == mirqc_pkg::MIRQC_SLEEP) && wake_req;
    assign asleep_o = (state_reg == mirqc_pkg::MIRQC_SLEEP);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            stack_push_o <= 1'b0;
            vector_o     <= '0;
        end else begin
            // one strobe per take; the core pushes its own return address
            stack_push_o    <= take;
            vector_o.take   <= take;
            vector_o.vector <= take ? `MIRQC_VECTOR : 13'h0000;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // assertions are grouped after the logic they guard; all run on the system clock
    sequence s_take;
        take;
    endsequence

    sequence s_vectored;
        stack_push_o && vector_o.take && (vector_o.vector == `MIRQC_VECTOR);
    endsequence

    sequence s_wake_event;
        asleep_o && wake_req;
    endsequence

    sequence s_left_sleep;
        !asleep_o && (state_reg == mirqc_pkg::MIRQC_WAKE_STEP);
    endsequence

    sequence s_pin_set;
        (ext_edge || ext_hold_reg) && q41;
    endsequence

    a_vector_after_take: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_take |=> s_vectored) else $error("no vector after take");

    a_master_cleared: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        take && !return_from_irq_instr_i |=> !control_reg[`MIRQC_BIT_MASTER])
        else $error("master enable kept after take");

    a_return_sets: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        return_from_irq_instr_i |=> control_reg[`MIRQC_BIT_MASTER])
        else $error("return did not set master");

    a_blocked_irq: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !control_reg[`MIRQC_BIT_MASTER] |-> !core_irq_o && !take)
        else $error("request while master clear");

    a_timer_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        timer8_ovf_i |=> control_reg[`MIRQC_BIT_T8_FLAG])
        else $error("timer flag not set");

    a_periph_flags: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        |periph_evt_i |=> ((pflags_reg & $past(periph_evt_i)) == $past(periph_evt_i)))
        else $error("peripheral flag lost");

    a_pin_flag_phase: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(control_reg[`MIRQC_BIT_EXT_FLAG]) && !$past(wr_ctl) |-> $past(q41))
        else $error("pin flag outside q4 q1");

    a_pending_kept: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        pending_reg && !control_reg[`MIRQC_BIT_MASTER] && !reg_write_i |=> pending_reg)
        else $error("blocked request dropped");

    a_reset_master: assert property (@(posedge clk_sys_i)
        reset_i |-> !control_reg[`MIRQC_BIT_MASTER])
        else $error("master set in reset");

    // vector word is zero outside the push so a stale address never reaches the core
    a_vector_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (vector_o.take == stack_push_o) && (stack_push_o || (vector_o.vector == 13'h0000)))
        else $error("vector outside push");

    a_pin_sets_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_pin_set |=> control_reg[`MIRQC_BIT_EXT_FLAG])
        else $error("pin edge did not set flag");

    a_port_sets_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        port_change |=> control_reg[`MIRQC_BIT_PC_FLAG])
        else $error("port change did not set flag");

    // the wake step follows the wake event directly, even with the master enable off
    a_sleep_wakes: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_wake_event |=> s_left_sleep)
        else $error("enabled request did not wake");

    // two-cycle opcodes stretch the boundary to eight clocks, so that is the bound
    a_take_latency: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        core_irq_o |-> ##[0:8] (take || !core_irq_o || wr_ctl || asleep_o))
        else $error("request not taken in time");

    a_gate_blocks: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !control_reg[`MIRQC_BIT_PGATE] &&
        !(control_reg[`MIRQC_BIT_EXT_EN] && control_reg[`MIRQC_BIT_EXT_FLAG]) &&
        !(control_reg[`MIRQC_BIT_T8_EN] && control_reg[`MIRQC_BIT_T8_FLAG]) &&
        !(control_reg[`MIRQC_BIT_PC_EN] && control_reg[`MIRQC_BIT_PC_FLAG]) |-> !core_irq_o)
        else $error("request with no enabled source");

    // flags only fall by a software write; hardware never clears them
    a_pflag_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !wr_pf |=> ((pflags_reg & $past(pflags_reg)) == $past(pflags_reg)))
        else $error("peripheral flag cleared by hardware");

    a_ctl_flags_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !wr_ctl |=> ((control_reg[2:0] & $past(control_reg[2:0])) == $past(control_reg[2:0])))
        else $error("control flag cleared by hardware");

    a_master_cause: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(control_reg[`MIRQC_BIT_MASTER]) |-> $past(wr_ctl || return_from_irq_instr_i))
        else $error("master enable set without cause");

    a_no_take_asleep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        asleep_o |-> !take)
        else $error("take while asleep");
endmodule

//--- tb/mirqc_core_model.sv
module mirqc_core_model (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    output logic      [1:0] q_phase_o,
    output logic            instr_end_o
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////
    // one clock per phase; every instruction is one cycle long, so a take
    // can only land at a q4, never in the middle of a two-cycle opcode
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            q_phase_o <= 2'h0;
        end else begin
            q_phase_o <= q_phase_o + 2'h1;
        end
    end
    assign instr_end_o = (q_phase_o == 2'h3) && !reset_i;
endmodule

//--- tb/mirqc_tb_top.sv
`include "mirqc_params.svh"
module mirqc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk_sys_i = 1'b0;
    logic                     reset_i   = 1'b1;
    logic [1:0]               q_phase;
    logic                     instr_end;
    logic                     ext_pin = 1'b0, edge_sel = 1'b0, t8_ovf = 1'b0;
    logic                     ret = 1'b0, sleep = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic                     port_rd = 1'b0;
    logic [7:0]               port_pins = 8'h00, wdata = 8'h00, rdata, m;
    logic [`MIRQC_ADDR_W-1:0] addr = '0;
    logic                     core_irq, push, wake, asleep;
    mirqc_pkg::mirqc_periph_t periph = '0;
    mirqc_pkg::mirqc_vec_t    vec;
    int                       failures = 0, n_tests = 0, cycles = 0, pushes = 0, p;

    always #2 clk_sys_i = ~clk_sys_i;

    mirqc_core_model i_mirqc_core_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .q_phase_o(q_phase), .instr_end_o(instr_end));

    // port reads only after the port change check; a change meeting a q2 read still sets the flag from the old latch
    mirqc_top i_mirqc_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .q_phase_i(q_phase),
        .ext_pin_i(ext_pin), .ext_edge_select_i(edge_sel), .port_pins_i(port_pins),
        .port_read_i(port_rd), .timer8_ovf_i(t8_ovf), .periph_evt_i(periph),
        .instr_end_i(instr_end), .return_from_irq_instr_i(ret), .sleep_instr_i(sleep),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_en), .reg_read_i(rd_en),
        .reg_rdata_o(rdata), .core_irq_o(core_irq), .stack_push_o(push), .vector_o(vec),
        .wake_o(wake), .asleep_o(asleep));

    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (push === 1'b1) pushes++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys_i);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [8:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys_i);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys_i);
        rd_en <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask

    // {sleep, return, timer8, peripherals}, one cycle wide
    task automatic pulse(input logic [10:0] v);
        @(posedge clk_sys_i);
        {sleep, ret, t8_ovf, periph} <= v;
        @(posedge clk_sys_i);
        {sleep, ret, t8_ovf, periph} <= '0;
    endtask

    task automatic wait_take();
        #1;
        for (int k = 0; k < 12 && push !== 1'b1; k++) begin
            @(posedge clk_sys_i);
            #1;
        end
        check("vector", {vec.take, 2'b00, vec.vector}, {1'b1, 2'b00, `MIRQC_VECTOR});
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        reset_i <= 1'b0;
        rd(`MIRQC_OFS_CONTROL, 8'h00, "control");
        rd(`MIRQC_OFS_CONTROL_HI, 8'h00, "control_hi");
        rd(`MIRQC_OFS_PFLAGS, 8'h00, "pflags");
        rd(`MIRQC_OFS_PENABLES, 8'h00, "penables");
        rd(9'h010, 8'h00, "unmapped");
        $display("test reset done");
        // timer8 and every peripheral source flag with all enables off
        pulse(11'h100);
        for (int i = 0; i < 8; i++) pulse(11'h001 << i);
        tick(2);
        rd(`MIRQC_OFS_CONTROL, 8'h04, "timer8 flag");
        rd(`MIRQC_OFS_PFLAGS, 8'hff, "pflags set");
        wr(`MIRQC_OFS_PENABLES, 8'hff);
        wr(`MIRQC_OFS_CONTROL, 8'h64);
        tick(8);
        check("master off", core_irq, 0);
        check("no take", 16'(pushes), 0);
        wr(`MIRQC_OFS_CONTROL, 8'ha4);
        wait_take();
        rd(`MIRQC_OFS_CONTROL, 8'h24, "master dropped");
        wr(`MIRQC_OFS_CONTROL, 8'h20);
        pulse(11'h200);
        rd(`MIRQC_OFS_CONTROL, 8'ha0, "master back");
        tick(8);
        check("gate off", core_irq, 0);
        check("one take", 16'(pushes), 1);
        wr(`MIRQC_OFS_PFLAGS, 8'h00);
        $display("test global done");
        wr(`MIRQC_OFS_CONTROL, 8'hc0);
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            wr(`MIRQC_OFS_PENABLES, ~m);
            pulse({3'b000, m});
            tick(8);
            check("masked", core_irq, 0);
            wr(`MIRQC_OFS_PENABLES, 8'hff);
            wait_take();
            rd(`MIRQC_OFS_CONTROL, 8'h40, "master cleared");
            wr(`MIRQC_OFS_PFLAGS, 8'h00);
            pulse(11'h200);
            rd(`MIRQC_OFS_CONTROL, 8'hc0, "master again");
        end
        $display("test peripherals done");
        wr(`MIRQC_OFS_CONTROL, 8'h00);
        for (int s = 0; s < 2; s++) begin
            edge_sel <= s[0];
            ext_pin  <= s[0];
            tick(12);
            wr(`MIRQC_OFS_CONTROL, 8'h00);
            ext_pin <= !s[0];
            tick(12);
            rd(`MIRQC_OFS_CONTROL, 8'h00, "wrong edge");
            ext_pin <= s[0];
            tick(12);
            rd(`MIRQC_OFS_CONTROL, 8'h02, "pin flag");
        end
        $display("test pin done");
        wr(`MIRQC_OFS_CONTROL, 8'h00);
        wr(`MIRQC_OFS_PORT_SEL, 8'h01);
        rd(`MIRQC_OFS_PORT_SEL, 8'h01, "port select");
        port_pins <= 8'h02;
        tick(12);
        rd(`MIRQC_OFS_CONTROL, 8'h00, "unselected pin");
        port_pins <= 8'h03;
        tick(12);
        rd(`MIRQC_OFS_CONTROL, 8'h01, "port change");
        port_rd <= 1'b1;
        tick(4);
        port_rd <= 1'b0;
        wr(`MIRQC_OFS_CONTROL, 8'h00);
        rd(`MIRQC_OFS_CONTROL, 8'h00, "port settled");
        $display("test port done");
        // wake by the pin, first with the master enable off, then on
        for (int g = 0; g < 2; g++) begin
            wr(`MIRQC_OFS_CONTROL, g ? 8'h90 : 8'h10);
            ext_pin <= 1'b0;
            tick(12);
            p = pushes;
            pulse(11'h400);
            tick(2);
            check("asleep", asleep, 1);
            ext_pin <= 1'b1;
            for (int k = 0; k < 12 && wake !== 1'b1; k++) begin
                tick(1);
                #1;
            end
            check("wake", wake, 1);
            if (g) wait_take();
            tick(12);
            check("awake", asleep, 0);
            check("takes", 16'(pushes - p), 16'(g));
        end
        $display("test sleep done");
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        tick(2);
        reset_i <= 1'b0;
        rd(`MIRQC_OFS_CONTROL, 8'h00, "control after reset");
        $display("test second reset done");
        complete_run();
    end
endmodule
